/* File: src/lcdpd_pkg.sv */
// Package: register map, field layout and timing constants of the panel driver
package lcdpd_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SEG_EN_LOW = 8'h00e5;
  localparam logic [7:0] ADDR_SEG_EN_MID_LOW = 8'h00e6;
  localparam logic [7:0] ADDR_SEG_EN_MID_HIGH = 8'h00e7;
  localparam logic [7:0] ADDR_SEG_EN_HIGH = 8'h00ee;
  localparam logic [7:0] ADDR_PANEL_CONTROL = 8'h00f9;
  localparam logic [7:0] ADDR_PANEL_CLOCK_CONTROL = 8'h00fa;
  localparam logic [7:0] ADDR_PIXEL_POINTER = 8'h00fb;
  localparam logic [7:0] ADDR_PIXEL_WINDOW = 8'h00fc;
  // Own register: power-down and crystal-ready status (read only)
  localparam logic [7:0] ADDR_PANEL_STATUS = 8'h00fd;
  // ----------------------------------------------------------------
  // Reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE = 8'h0000;
  localparam logic [7:0] MASK_PANEL_CONTROL = 8'h00df;
  localparam logic [7:0] MASK_PANEL_CLOCK_CONTROL = 8'h0037;
  localparam logic [7:0] MASK_PIXEL_POINTER = 8'h001f;
  localparam logic [7:0] MASK_PIXEL_WINDOW = 8'h003f;
  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [1:0] DUTY_QUARTER = 2'h0;
  localparam logic [1:0] DUTY_THIRD = 2'h1;
  localparam logic [1:0] DUTY_SIXTH = 2'h2;
  localparam logic [1:0] SRC_SYSTEM = 2'h0;
  localparam logic [1:0] SRC_CRYSTAL = 2'h1;
  localparam logic [1:0] SRC_RC_OSC = 2'h2;
  localparam logic [2:0] DIV_MAX_CODE = 3'h5;
  localparam int SYS_PRESCALE_LOG2 = 12;
  localparam int LOW_PRESCALE_LOG2 = 4;
  localparam int COM_COUNT = 6;
  localparam int SEG_COUNT = 32;
  localparam int XTAL_IN_SEG = 29;
  localparam int XTAL_OUT_SEG = 30;

  // Control fields as they leave the control register
  typedef struct packed {
    logic display_on;
    logic drive_level_trim;
    logic reserved;
    logic half_bias;
    logic [1:0] duty;
    logic [1:0] ladder_value_sel;
  } lcdpd_ctrl_t;

  typedef struct packed {
    logic [1:0] reserved_hi;
    logic [1:0] panel_clk_source;
    logic reserved_lo;
    logic [2:0] panel_clk_divider;
  } lcdpd_clk_t;

  // Scan state handed to the pins
  typedef struct packed {
    logic [COM_COUNT-1:0] com_active;
    logic [COM_COUNT-1:0] com_select;
    logic frame_phase;
  } lcdpd_scan_t;
endpackage

/* File: src/lcdpd_pixel_mem.sv */
// Display data memory: one six-bit word per segment, registered read
`timescale 1ns/1ps
module lcdpd_pixel_mem #(
  parameter int DEPTH = 32,
  parameter int WIDTH = 6
) (
  // Clock
  input wire logic clk,
  // Software port
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] addr,
  input wire logic [WIDTH-1:0] wr_data,
  output logic [WIDTH-1:0] rd_data,
  // Scan port: all words at once
  output logic [DEPTH*WIDTH-1:0] all_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  // Write and registered read
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[addr] <= wr_data;
    end
    rd_data <= mem[addr];
  end

  // Flatten for the segment drivers
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      all_data[i*WIDTH +: WIDTH] = mem[i];
    end
  end
endmodule // lcdpd_pixel_mem

/* File: src/lcdpd_top.sv */
// Segment panel driver: register file, clock divider, common scan and pin control
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
// Overview of operation
// - Display off returns all pins to I/O; on drives commons and enabled segments
// - Bias bit: 0 selects one-third bias, 1 selects one-half bias
// - Duty 00 quarter, 01 third, 10 sixth; at third duty common 3 is I/O
// - At sixth duty segment pins 0 and 1 act as commons 4 and 5
// - Ladder select 00/01/10 picks 150, 300, 600 kOhm; 11 reserved
// - Clock source: system/2^12, crystal/2^4, RC oscillator/2^4; 11 reserved
// - Low-speed clock sources keep scanning during power-down
// - With crystal source segment pins 29 and 30 are not driven
// - Divider codes 000 to 101 divide by 1 to 32; others reserved
// - Five-bit pointer selects the display register behind the window
// - Window write stores six pixel bits; 1 darkens, 0 clears
// - Each segment pin has its own enable bit in four byte registers
// - Enabled driven segment reads its I/O data bit as 0; writes latch
// - Thirty-two display registers, one per segment, bits per common
// - Commons are activated one after another, as many as duty needs
// - At sixth duty enable bits of segments 0 and 1 are ignored for driving; they still mask I/O reads
module lcdpd_top #(
  parameter int SEGMENTS = 32,
  parameter int COMMONS = 6,
  parameter int SYS_PRESCALE = 4096
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Low-speed clock ticks, already in this domain, and system state
  input wire logic crystal_tick,
  input wire logic rc_osc_tick,
  input wire logic crystal_ready,
  input wire logic power_down,
  // Panel outputs
  output lcdpd_pkg::lcdpd_scan_t scan,
  output logic half_bias,
  output logic drive_level_trim,
  output logic [1:0] ladder_value_sel,
  output logic [COMMONS-1:0] com_drive_en,
  output logic [SEGMENTS-1:0] seg_drive_en,
  output logic [SEGMENTS-1:0] seg_dark,
  // I/O data read masking
  input wire logic [SEGMENTS-1:0] io_pin_data,
  output logic [SEGMENTS-1:0] io_read_data
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  lcdpd_pkg::lcdpd_ctrl_t ctrl;
  lcdpd_pkg::lcdpd_clk_t clk_ctrl;
  logic [4:0] pointer;
  logic [SEGMENTS-1:0] seg_en;
  logic [5:0] mem_rdata;
  logic [SEGMENTS*6-1:0] mem_all;
  logic window_wr;
  logic rd_pending;
  logic [7:0] rd_addr;
  logic [7:0] next_rdata;

  // Is the address a known register
  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      lcdpd_pkg::ADDR_SEG_EN_LOW, lcdpd_pkg::ADDR_SEG_EN_MID_LOW,
      lcdpd_pkg::ADDR_SEG_EN_MID_HIGH, lcdpd_pkg::ADDR_SEG_EN_HIGH,
      lcdpd_pkg::ADDR_PANEL_CONTROL, lcdpd_pkg::ADDR_PANEL_CLOCK_CONTROL,
      lcdpd_pkg::ADDR_PIXEL_POINTER, lcdpd_pkg::ADDR_PIXEL_WINDOW,
      lcdpd_pkg::ADDR_PANEL_STATUS: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  // Control register writes, reserved bits masked
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= lcdpd_pkg::RESET_BYTE;
      clk_ctrl <= lcdpd_pkg::RESET_BYTE;
      pointer <= 5'h00;
    end else if (reg_wr) begin
      case (reg_addr)
        lcdpd_pkg::ADDR_PANEL_CONTROL: begin
          ctrl <= reg_wdata & lcdpd_pkg::MASK_PANEL_CONTROL;
        end
        lcdpd_pkg::ADDR_PANEL_CLOCK_CONTROL: begin
          clk_ctrl <= reg_wdata & lcdpd_pkg::MASK_PANEL_CLOCK_CONTROL;
        end
        lcdpd_pkg::ADDR_PIXEL_POINTER: begin
          pointer <= reg_wdata[4:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Segment enable bytes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      seg_en <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        lcdpd_pkg::ADDR_SEG_EN_LOW: seg_en[7:0] <= reg_wdata;
        lcdpd_pkg::ADDR_SEG_EN_MID_LOW: seg_en[15:8] <= reg_wdata;
        lcdpd_pkg::ADDR_SEG_EN_MID_HIGH: seg_en[23:16] <= reg_wdata;
        lcdpd_pkg::ADDR_SEG_EN_HIGH: seg_en[31:24] <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // Window writes go to the pointed display word
  assign window_wr = reg_wr && (reg_addr == lcdpd_pkg::ADDR_PIXEL_WINDOW);

  lcdpd_pixel_mem #(
    .DEPTH(SEGMENTS),
    .WIDTH(6)
  ) u_mem (
    .clk(clk),
    .wr_en(window_wr),
    .addr(pointer),
    .wr_data(reg_wdata[5:0]),
    .rd_data(mem_rdata),
    .all_data(mem_all)
  );

  // Read address held one cycle; data muxed in the answer cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_pending <= 1'b0;
      rd_addr <= 8'h00;
    end else begin
      rd_pending <= reg_rd;
      rd_addr <= reg_addr;
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (rd_pending && is_mapped(rd_addr)) begin
      case (rd_addr)
        lcdpd_pkg::ADDR_SEG_EN_LOW: next_rdata = seg_en[7:0];
        lcdpd_pkg::ADDR_SEG_EN_MID_LOW: next_rdata = seg_en[15:8];
        lcdpd_pkg::ADDR_SEG_EN_MID_HIGH: next_rdata = seg_en[23:16];
        lcdpd_pkg::ADDR_SEG_EN_HIGH: next_rdata = seg_en[31:24];
        lcdpd_pkg::ADDR_PANEL_CONTROL: next_rdata = ctrl;
        lcdpd_pkg::ADDR_PANEL_CLOCK_CONTROL: next_rdata = clk_ctrl;
        lcdpd_pkg::ADDR_PIXEL_POINTER: next_rdata = {3'h0, pointer};
        lcdpd_pkg::ADDR_PIXEL_WINDOW: next_rdata = {2'h0, mem_rdata};
        lcdpd_pkg::ADDR_PANEL_STATUS: next_rdata = {6'h00, crystal_ready, power_down};
        default: next_rdata = 8'h00;
      endcase
    end
  end
  assign reg_rdata = next_rdata;

  // ----------------------------------------------------------------
  // Panel clock
  // ----------------------------------------------------------------
  logic src_tick;
  logic [11:0] sys_pre;
  logic [3:0] low_pre;
  logic pre_tick;
  logic [4:0] div_cnt;
  logic [4:0] div_limit;
  logic panel_tick;
  logic low_speed_src;

  assign low_speed_src = (clk_ctrl.panel_clk_source == lcdpd_pkg::SRC_CRYSTAL) ||
                         (clk_ctrl.panel_clk_source == lcdpd_pkg::SRC_RC_OSC);

  // Source select; system clock is gated off in power-down
  always_comb begin
    case (clk_ctrl.panel_clk_source)
      lcdpd_pkg::SRC_SYSTEM: src_tick = !power_down;
      lcdpd_pkg::SRC_CRYSTAL: src_tick = crystal_tick;
      lcdpd_pkg::SRC_RC_OSC: src_tick = rc_osc_tick;
      default: src_tick = 1'b0;
    endcase
  end

  // Prescalers by 2^12 and 2^4
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sys_pre <= 12'h000;
      low_pre <= 4'h0;
    end else if (src_tick && ctrl.display_on) begin
      if (low_speed_src) begin
        low_pre <= low_pre + 4'h1;
      end else begin
        sys_pre <= (sys_pre == 12'(SYS_PRESCALE - 1)) ? 12'h000 : sys_pre + 12'h001;
      end
    end
  end

  assign pre_tick = src_tick && ctrl.display_on &&
                    (low_speed_src ? (low_pre == 4'hf)
                                   : (sys_pre == 12'(SYS_PRESCALE - 1)));

  // Divider by 1..32; reserved codes stop the clock
  always_comb begin
    case (clk_ctrl.panel_clk_divider)
      3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5:
        div_limit = 5'((6'h01 << clk_ctrl.panel_clk_divider) - 6'h01);
      default: div_limit = 5'h00;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt <= 5'h00;
    end else if (pre_tick) begin
      div_cnt <= (div_cnt >= div_limit) ? 5'h00 : div_cnt + 5'h01;
    end
  end

  assign panel_tick = pre_tick && (div_cnt >= div_limit) &&
                      (clk_ctrl.panel_clk_divider <= lcdpd_pkg::DIV_MAX_CODE);

  // ----------------------------------------------------------------
  // Common scan
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    COM0 = 3'h0, COM1 = 3'h1, COM2 = 3'h3, COM3 = 3'h2, COM4 = 3'h6, COM5 = 3'h7
  } lcdpd_com_t;
  lcdpd_com_t com_state;
  lcdpd_com_t next_com;
  logic last_com;
  logic phase;

  always_comb begin
    case (ctrl.duty)
      lcdpd_pkg::DUTY_THIRD: last_com = (com_state == COM2);
      lcdpd_pkg::DUTY_SIXTH: last_com = (com_state == COM5);
      default: last_com = (com_state == COM3);
    endcase
    case (com_state)
      COM0: next_com = COM1;
      COM1: next_com = COM2;
      COM2: next_com = last_com ? COM0 : COM3;
      COM3: next_com = last_com ? COM0 : COM4;
      COM4: next_com = COM5;
      default: next_com = COM0;
    endcase
  end

  // Step one common per panel tick, alternate polarity per frame
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      com_state <= COM0;
      phase <= 1'b0;
    end else if (!ctrl.display_on) begin
      com_state <= COM0;
      phase <= 1'b0;
    end else if (panel_tick) begin
      com_state <= next_com;
      if (last_com) begin
        phase <= !phase;
      end
    end
  end

  // Index of current common
  function automatic logic [2:0] com_index(input lcdpd_com_t s);
    case (s)
      COM0: com_index = 3'h0;
      COM1: com_index = 3'h1;
      COM2: com_index = 3'h2;
      COM3: com_index = 3'h3;
      COM4: com_index = 3'h4;
      default: com_index = 3'h5;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Pin control
  // ----------------------------------------------------------------
  logic sixth;
  logic [COMMONS-1:0] com_used;
  logic [SEGMENTS-1:0] seg_active;
  logic [SEGMENTS-1:0] next_dark;

  assign sixth = (ctrl.duty == lcdpd_pkg::DUTY_SIXTH);

  always_comb begin
    com_used = 6'h0f;
    if (ctrl.duty == lcdpd_pkg::DUTY_THIRD) begin
      com_used = 6'h07;
    end else if (sixth) begin
      com_used = 6'h3f;
    end
    com_drive_en = ctrl.display_on ? com_used : 6'h00;
    seg_active = ctrl.display_on ? seg_en : '0;
    if (sixth) begin
      seg_active[1:0] = 2'h0;
    end
    if (clk_ctrl.panel_clk_source == lcdpd_pkg::SRC_CRYSTAL) begin
      seg_active[lcdpd_pkg::XTAL_IN_SEG] = 1'b0;
      seg_active[lcdpd_pkg::XTAL_OUT_SEG] = 1'b0;
    end
    seg_drive_en = seg_active;
    for (int i = 0; i < SEGMENTS; i++) begin
      next_dark[i] = mem_all[i*6 + int'(com_index(com_state))];
    end
  end

  // Registered pixel levels and scan state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      seg_dark <= '0;
      scan <= '0;
    end else begin
      seg_dark <= next_dark & seg_active;
      scan.com_active <= com_drive_en;
      scan.com_select <= ctrl.display_on ? (6'h01 << com_index(com_state)) : 6'h00;
      scan.frame_phase <= phase;
    end
  end

  // Analog settings
  assign half_bias = ctrl.half_bias;
  assign drive_level_trim = ctrl.drive_level_trim;
  assign ladder_value_sel = ctrl.ladder_value_sel;

  // I/O data reads masked on enabled segments while the display is on
  assign io_read_data = io_pin_data & ~(seg_en & {SEGMENTS{ctrl.display_on}});

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_window_write;
    reg_wr && reg_addr == lcdpd_pkg::ADDR_PIXEL_WINDOW;
  endsequence

  chk_off_no_drive: assert property (@(posedge clk) disable iff (!arst_n)
    !ctrl.display_on |-> seg_drive_en == '0 && com_drive_en == '0)
    else $error("pins driven while display off");
  chk_third_duty_com: assert property (@(posedge clk) disable iff (!arst_n)
    ctrl.display_on && ctrl.duty == lcdpd_pkg::DUTY_THIRD |-> !com_drive_en[3])
    else $error("common 3 driven at third duty");
  chk_sixth_commons: assert property (@(posedge clk) disable iff (!arst_n)
    ctrl.display_on && sixth |-> com_drive_en[5:4] == 2'h3 && seg_drive_en[1:0] == 2'h0)
    else $error("sixth duty pins wrong");
  chk_crystal_pins: assert property (@(posedge clk) disable iff (!arst_n)
    clk_ctrl.panel_clk_source == lcdpd_pkg::SRC_CRYSTAL |->
    !seg_drive_en[lcdpd_pkg::XTAL_IN_SEG] && !seg_drive_en[lcdpd_pkg::XTAL_OUT_SEG])
    else $error("crystal pins driven");
  chk_window_readback: assert property (@(posedge clk) disable iff (!arst_n)
    s_window_write ##1 (reg_rd && reg_addr == lcdpd_pkg::ADDR_PIXEL_WINDOW && !reg_wr)
    |=> reg_rdata == ($past(reg_wdata, 2) & lcdpd_pkg::MASK_PIXEL_WINDOW))
    else $error("window readback mismatch");
  chk_io_masked: assert property (@(posedge clk) disable iff (!arst_n)
    ctrl.display_on |-> (io_read_data & seg_en) == '0)
    else $error("enabled segment io read not zero");
  chk_reserved_zero: assert property (@(posedge clk) disable iff (!arst_n)
    reg_rd && reg_addr == lcdpd_pkg::ADDR_PANEL_CLOCK_CONTROL |=> reg_rdata[7:6] == 2'h0)
    else $error("reserved bits nonzero");
  chk_scan_steps: assert property (@(posedge clk) disable iff (!arst_n)
    panel_tick && ctrl.display_on && !reg_wr && com_state == COM0 |=> com_state == COM1)
    else $error("scan did not advance");
  chk_powerdown_run: assert property (@(posedge clk) disable iff (!arst_n)
    power_down && clk_ctrl.panel_clk_source == lcdpd_pkg::SRC_SYSTEM |-> !pre_tick)
    else $error("system source ran in power-down");
endmodule // lcdpd_top

/* File: sim/lcdpd_panel_model.sv */
// Panel glass model: watches the scanned commons and the pixel levels shown on them
`timescale 1ns/1ps
module lcdpd_panel_model (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Driver side
  input wire lcdpd_pkg::lcdpd_scan_t scan,
  input wire logic [5:0] com_drive_en,
  input wire logic [31:0] seg_dark,
  input wire logic clear,
  // Observations
  output int step_count,
  output int last_gap,
  output logic [5:0] com_seen,
  output logic [5:0][31:0] dark_seen
);
  logic [5:0] prev_sel;
  logic [5:0] prev2_sel;
  int gap;

  // ----------------------------------------------------------------
  // Scan watch
  // ----------------------------------------------------------------
  // Count common changes, the cycles between them and the driven commons seen
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_sel <= '0;
      prev2_sel <= '0;
      gap <= 0;
      step_count <= 0;
      last_gap <= 0;
      com_seen <= '0;
    end else begin
      prev_sel <= scan.com_select;
      prev2_sel <= prev_sel;
      gap <= gap + 1;
      if (scan.com_select != prev_sel) begin
        step_count <= step_count + 1;
        last_gap <= gap;
        gap <= 1;
      end
      com_seen <= clear ? '0 : com_seen | (scan.com_select & com_drive_en);
    end
  end

  // Pixel levels a common shows once it has settled for two cycles
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dark_seen <= '0;
    end else begin
      for (int c = 0; c < 6; c++) begin
        if (scan.com_select[c] && prev_sel == scan.com_select && prev2_sel == prev_sel) begin
          dark_seen[c] <= seg_dark;
        end
      end
    end
  end
endmodule // lcdpd_panel_model

/* File: sim/lcdpd_top_tb_top.sv */
// Testbench: register access, pin control and scan checks of the panel driver
`timescale 1ns/1ps
module lcdpd_top_tb_top;
  localparam int SYS_PRE = 4;
  localparam logic [7:0] A_CTL = lcdpd_pkg::ADDR_PANEL_CONTROL;
  localparam logic [7:0] A_CLK = lcdpd_pkg::ADDR_PANEL_CLOCK_CONTROL;
  localparam logic [7:0] A_PTR = lcdpd_pkg::ADDR_PIXEL_POINTER;
  localparam logic [7:0] A_WIN = lcdpd_pkg::ADDR_PIXEL_WINDOW;
  localparam logic [31:0] SEG_EN = 32'h7e81_3ca7;
  logic clk, arst_n, reg_wr, reg_rd, crystal_tick, rc_osc_tick, crystal_ready;
  logic power_down, clear, half_bias, drive_level_trim, ph;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [1:0] ladder_value_sel;
  logic [5:0] com_drive_en, com_seen, pv;
  logic [31:0] seg_drive_en, seg_dark, io_pin_data, io_read_data, e;
  logic [5:0][31:0] dark_seen;
  lcdpd_pkg::lcdpd_scan_t scan;
  int step_count, last_gap, failures, samples_checked, xt_cnt, rc_cnt, s;
  logic [7:0] ta [9] = '{8'he5, 8'he6, 8'he7, 8'hee, A_CTL, A_CLK, A_PTR, A_WIN, 8'h00};
  logic [7:0] te [9] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hdf, 8'h37, 8'h1f, 8'h3f, 8'h00};
  logic [5:0] ce [3] = '{6'h0f, 6'h07, 6'h3f};

  // ----------------------------------------------------------------
  // Design, panel and clocks
  // ----------------------------------------------------------------
  lcdpd_top #(.SYS_PRESCALE(SYS_PRE)) lcdpd_top_i (.clk(clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .crystal_tick(crystal_tick), .rc_osc_tick(rc_osc_tick),
    .crystal_ready(crystal_ready), .power_down(power_down), .scan(scan),
    .half_bias(half_bias), .drive_level_trim(drive_level_trim),
    .ladder_value_sel(ladder_value_sel), .com_drive_en(com_drive_en),
    .seg_drive_en(seg_drive_en), .seg_dark(seg_dark), .io_pin_data(io_pin_data),
    .io_read_data(io_read_data));
  lcdpd_panel_model lcdpd_panel_model_i (.clk(clk), .arst_n(arst_n), .scan(scan),
    .com_drive_en(com_drive_en), .seg_dark(seg_dark), .clear(clear),
    .step_count(step_count), .last_gap(last_gap), .com_seen(com_seen), .dark_seen(dark_seen));

  // Clock at 5 ns
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Low-speed oscillator pulses: crystal every 3 cycles, RC every 5
  always @(posedge clk) begin
    xt_cnt <= (xt_cnt == 2) ? 0 : xt_cnt + 1;
    rc_cnt <= (rc_cnt == 4) ? 0 : rc_cnt + 1;
    crystal_tick <= (xt_cnt == 2);
    rc_osc_tick <= (rc_cnt == 4);
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic idle;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  // Read data stand in the cycle after the strobe, sampled just past the edge
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    @(posedge clk);
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic wait_steps(input int n);
    int s0;
    int k;
    s0 = step_count;
    k = 0;
    while (step_count < s0 + n && k < 3000) begin
      idle;
      k++;
    end
    chk(32'(k < 3000), 32'h1);
  endtask

  function automatic logic [5:0] pat(input int p);
    return 6'(p * 7 + 5);
  endfunction

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    print_verdict;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {arst_n, reg_wr, reg_rd, crystal_ready, power_down, clear} = '0;
    {failures, samples_checked} = '0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    io_pin_data = 32'hffff_ffff;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    idle;
    for (int i = 0; i < 9; i++) rdchk(ta[i], 8'h00);
    for (int i = 0; i < 9; i++) begin
      wr(ta[i], 8'hff);
      rdchk(ta[i], te[i]);
    end
    chk({half_bias, drive_level_trim, ladder_value_sel}, 4'hf);
    for (int i = 0; i < 3; i++) begin
      wr(A_CTL, {1'b0, i[0], 1'b0, i[0], 2'b00, i[1:0]});
      chk({half_bias, drive_level_trim, ladder_value_sel}, {i[0], i[0], i[1:0]});
    end
    power_down <= 1'b1;
    idle;
    rdchk(8'hfd, 8'h01);
    power_down <= 1'b0;
    crystal_ready <= 1'b1;
    idle;
    rdchk(8'hfd, 8'h02);
    // Pin ownership by duty, display state and clock source
    for (int i = 0; i < 4; i++) wr(ta[i], SEG_EN[i*8 +: 8]);
    wr(A_CTL, 8'h00);
    chk(com_drive_en, 6'h00);
    chk(seg_drive_en, 32'h0);
    chk(io_read_data, io_pin_data);
    for (int d = 0; d < 3; d++) begin
      wr(A_CTL, 8'h80 | 8'(d << 2));
      e = (d == 2) ? SEG_EN & 32'hffff_fffc : SEG_EN;
      chk(com_drive_en, ce[d]);
      chk(seg_drive_en, e);
    end
    wr(A_CTL, 8'h80);
    chk(io_read_data, ~SEG_EN);
    wr(A_CLK, 8'h10);
    chk(seg_drive_en, 32'h1e81_3ca7);
    wr(A_CLK, 8'h20);
    chk(seg_drive_en, SEG_EN);
    // Pixel memory through pointer and window; reserved data bits written high
    for (int p = 0; p < 32; p++) begin
      wr(A_PTR, 8'(p));
      wr(A_WIN, {2'b11, pat(p)});
    end
    for (int p = 31; p >= 0; p--) begin
      wr(A_PTR, 8'(p));
      rdchk(A_WIN, {2'b00, pat(p)});
    end
    // Commons scanned per duty; display is off while duty changes
    wr(A_CLK, 8'h02);
    for (int d = 0; d < 3; d++) begin
      wr(A_CTL, 8'(d << 2));
      wr(A_CTL, 8'h80 | 8'(d << 2));
      clear <= 1'b1;
      idle;
      clear <= 1'b0;
      wait_steps(14);
      chk(com_seen, ce[d]);
      chk(scan.com_active, ce[d]);
    end
    wr(A_CTL, 8'h00);
    wr(A_CTL, 8'h80);
    wait_steps(10);
    // Only enabled segments show their pixels
    for (int c = 0; c < 4; c++) begin
      for (int p = 0; p < 32; p++) begin
        pv = pat(p);
        e[p] = pv[c];
      end
      chk(dark_seen[c], e & SEG_EN);
    end
    // One full quarter-duty frame flips the polarity once
    ph = scan.frame_phase;
    wait_steps(4);
    chk(scan.frame_phase, !ph);
    // Step spacing for every divider and every source
    for (int k = 0; k < 6; k++) begin
      wr(A_CLK, 8'(k));
      wait_steps(3);
      chk(last_gap, SYS_PRE << k);
    end
    wr(A_CLK, 8'h10);
    wait_steps(3);
    chk(last_gap, 48);
    wr(A_CLK, 8'h20);
    wait_steps(3);
    chk(last_gap, 80);
    // Power-down keeps low-speed sources scanning and stops the system source
    power_down <= 1'b1;
    wait_steps(3);
    wr(A_CLK, 8'h10);
    wait_steps(3);
    wr(A_CLK, 8'h00);
    repeat (5) idle;
    s = step_count;
    repeat (100) idle;
    chk(step_count, s);
    power_down <= 1'b0;
    wr(A_CLK, 8'h06);
    repeat (5) idle;
    s = step_count;
    repeat (200) idle;
    chk(step_count, s);
    print_verdict;
  end
endmodule // lcdpd_top_tb_top
